// ===== shared/ctcp_pkg.sv
`default_nettype none
package ctcp_pkg;
  localparam int CTCP_CNT_W = 10;
  localparam int CTCP_CODE_W = 3;
  localparam int CTCP_P_SHIFT = 7;
  localparam int CTCP_FLAG_N = 2;

  localparam logic [7:0] CTCP_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] CTCP_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] CTCP_ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] CTCP_ADDR_CNT_HI = 8'h0c;
  localparam logic [7:0] CTCP_ADDR_CMP_LO = 8'h10;
  localparam logic [7:0] CTCP_ADDR_CMP_HI = 8'h14;
  localparam logic [7:0] CTCP_ADDR_STATUS = 8'h18;

  localparam int CTCP_ON_BIT = 3;
  localparam int CTCP_MODE_LSB = 6;
  localparam int CTCP_ACT_LSB = 4;
  localparam int CTCP_OC_BIT = 3;
  localparam int CTCP_POL_BIT = 2;
  localparam int CTCP_SWAP_BIT = 1;
  localparam int CTCP_CLR_BIT = 0;
  localparam int CTCP_FLAG_A = 0;
  localparam int CTCP_FLAG_P = 1;

  localparam logic [9:0] CTCP_CNT_RST = 10'h000;
  localparam logic [9:0] CTCP_CNT_MAX = 10'h3ff;
  localparam logic [10:0] CTCP_FULL_SPAN = 11'h400;
  localparam logic [2:0] CTCP_CODE_RST = 3'h0;
  localparam logic [31:0] CTCP_RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    CTCP_MODE_CMP = 2'b00,
    CTCP_MODE_UNDEF = 2'b01,
    CTCP_MODE_PWM = 2'b10,
    CTCP_MODE_TMR = 2'b11
  } ctcp_mode_t;

  localparam logic [1:0] CTCP_ACT_NONE = 2'b00;
  localparam logic [1:0] CTCP_ACT_LOW = 2'b01;
  localparam logic [1:0] CTCP_ACT_HIGH = 2'b10;
  localparam logic [1:0] CTCP_ACT_TOGGLE = 2'b11;
  localparam logic [1:0] CTCP_PWM_INACT = 2'b00;
  localparam logic [1:0] CTCP_PWM_ACT = 2'b01;
  localparam logic [1:0] CTCP_PWM_RUN = 2'b10;
endpackage
`default_nettype wire

// ===== hw/ctcp_compare.sv
`default_nettype none
module ctcp_compare
  import ctcp_pkg::*;
(
  input wire logic [9:0] cnt_in,
  input wire logic [9:0] next_in,
  input wire logic [9:0] cmp_a_in,
  input wire logic [2:0] code_in,
  input wire logic swap_in,
  output logic match_a_out,
  output logic match_p_out,
  output logic duty_on_out
);
  logic [10:0] p_edge;

  // Code zero stands for the full 1024-count span, which the counter reaches by wrapping.
  assign p_edge = (code_in == CTCP_CODE_RST) ? CTCP_FULL_SPAN : {1'b0, code_in, 7'b000_0000};
  assign match_p_out = (next_in == p_edge[9:0]);
  // A zero compare A never matches, so the counter simply wraps at its maximum.
  assign match_a_out = (cmp_a_in != CTCP_CNT_RST) && (next_in == cmp_a_in);
  // A duty at or beyond the period keeps this high for the whole period.
  assign duty_on_out = swap_in ? ({1'b0, cnt_in} < p_edge) : (cnt_in < cmp_a_in);
endmodule
`default_nettype wire

// ===== hw/ctcp_rise.sv
`default_nettype none
module ctcp_rise (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic level_in,
  output logic rise_out
);
  logic prev_q;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      prev_q <= 1'b0;
    end else if (ce_in) begin
      prev_q <= level_in;
    end
  end

  assign rise_out = level_in & ~prev_q;
endmodule
`default_nettype wire

// ===== hw/ctcp_timer.sv
// Register access over APB and the register offsets are this design's own decisions.
`default_nettype none
// Functional notes
// - Counter readable as low and high bytes.
// - Compare A readable and writable, two bytes.
// - Mode field selects compare, timer, PWM.
// - Clear on P match; both flags raised.
// - Clear-select high: clear on A, no P.
// - Zero compare A: wrap, no A flag.
// - Only A matches move pin in compare.
// - A match drives high, low or toggles.
// - Action 01 low, 10 high, 11 toggle.
// - Timer on rise loads initial pin level.
// - Timer on rise zeroes counter; fall keeps.
// - Timer mode counts alike, pin undriven.
// - PWM ignores clear-select; swap picks roles.
// - Swap low: period 128 times code (code 0: 1024).
// - Swap high: period A, duty code steps.
// - Duty at or over period: full duty.
// - PWM raises A and P flags.
// - Initial level sets polarity; invert bit flips.
// - PWM action: inactive, active, waveform.
// - PWM counting runs while output forced.
// - Period code times 128 compared with counter plus one.
module ctcp_timer
  import ctcp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic count_tick_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic match_a_flag_out,
  output logic match_p_flag_out,
  output logic timer_pin_out,
  output logic timer_pin_oe_out
);
  logic timer_on_q;
  logic [2:0] period_code_q;
  ctcp_mode_t mode_q;
  logic [1:0] action_q;
  logic init_level_q;
  logic invert_q;
  logic swap_q;
  logic clear_sel_q;
  logic [9:0] cmp_a_q;
  logic [9:0] cnt_q;
  logic [9:0] cnt_next;
  logic [1:0] flag_q;
  logic [1:0] flag_set;
  logic pin_state_q;
  logic pin_out_q;
  logic pin_oe_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata;
  logic mapped;
  logic access;
  logic wr_fire;
  logic on_rise;
  logic run;
  logic match_a;
  logic match_p;
  logic duty_on;
  logic clear_now;
  logic is_pwm;
  logic pwm_level;
  logic pin_d;
  logic pin_oe_d;
  logic flag_clr_wr;

  assign access = psel_in & penable_in;
  // Writes land on the edge where the master sees pready high, never earlier.
  assign wr_fire = access & pready_q & pwrite_in;
  assign flag_clr_wr = wr_fire && (paddr_in == CTCP_ADDR_STATUS);
  assign is_pwm = (mode_q == CTCP_MODE_PWM);
  assign cnt_next = cnt_q + 10'h001;

  ctcp_rise u_on_rise (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .level_in(timer_on_q),
    .rise_out(on_rise)
  );

  ctcp_compare u_compare (
    .cnt_in(cnt_q),
    .next_in(cnt_next),
    .cmp_a_in(cmp_a_q),
    .code_in(period_code_q),
    .swap_in(swap_q),
    .match_a_out(match_a),
    .match_p_out(match_p),
    .duty_on_out(duty_on)
  );

  // The timer-on rising edge takes priority over a count in the same cycle.
  assign run = timer_on_q & count_tick_in & ~on_rise;

  always_comb begin
    if (is_pwm) begin
      clear_now = swap_q ? match_a : match_p;
    end else if (clear_sel_q) begin
      clear_now = match_a;
    end else begin
      clear_now = match_p;
    end
  end

  assign flag_set[CTCP_FLAG_A] = run & match_a;
  assign flag_set[CTCP_FLAG_P] = run & match_p & (is_pwm | ~clear_sel_q);

  always_comb begin
    rdata = CTCP_RDATA_RST;
    mapped = 1'b1;
    case (paddr_in)
      CTCP_ADDR_CTRL0: begin
        rdata[CTCP_ON_BIT] = timer_on_q;
        rdata[2:0] = period_code_q;
      end
      CTCP_ADDR_CTRL1: begin
        rdata[7:0] = {mode_q, action_q, init_level_q, invert_q, swap_q, clear_sel_q};
      end
      CTCP_ADDR_CNT_LO: begin
        rdata[7:0] = cnt_q[7:0];
      end
      CTCP_ADDR_CNT_HI: begin
        rdata[1:0] = cnt_q[9:8];
      end
      CTCP_ADDR_CMP_LO: begin
        rdata[7:0] = cmp_a_q[7:0];
      end
      CTCP_ADDR_CMP_HI: begin
        rdata[1:0] = cmp_a_q[9:8];
      end
      CTCP_ADDR_STATUS: begin
        rdata[1:0] = flag_q;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // One wait state keeps pready and read data coming straight from flops.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= CTCP_RDATA_RST;
    end else if (ce_in) begin
      pready_q <= access & ~pready_q;
      if (access & ~pready_q) begin
        pslverr_q <= ~mapped;
        prdata_q <= pwrite_in ? CTCP_RDATA_RST : rdata;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      timer_on_q <= 1'b0;
      period_code_q <= CTCP_CODE_RST;
    end else if (ce_in && wr_fire && (paddr_in == CTCP_ADDR_CTRL0)) begin
      timer_on_q <= pwdata_in[CTCP_ON_BIT];
      period_code_q <= pwdata_in[2:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      mode_q <= CTCP_MODE_CMP;
      action_q <= CTCP_ACT_NONE;
      init_level_q <= 1'b0;
      invert_q <= 1'b0;
      swap_q <= 1'b0;
      clear_sel_q <= 1'b0;
    end else if (ce_in && wr_fire && (paddr_in == CTCP_ADDR_CTRL1)) begin
      mode_q <= ctcp_mode_t'(pwdata_in[CTCP_MODE_LSB +: 2]);
      action_q <= pwdata_in[CTCP_ACT_LSB +: 2];
      init_level_q <= pwdata_in[CTCP_OC_BIT];
      invert_q <= pwdata_in[CTCP_POL_BIT];
      swap_q <= pwdata_in[CTCP_SWAP_BIT];
      clear_sel_q <= pwdata_in[CTCP_CLR_BIT];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cmp_a_q <= CTCP_CNT_RST;
    end else if (ce_in && wr_fire) begin
      if (paddr_in == CTCP_ADDR_CMP_LO) begin
        cmp_a_q[7:0] <= pwdata_in[7:0];
      end else if (paddr_in == CTCP_ADDR_CMP_HI) begin
        cmp_a_q[9:8] <= pwdata_in[1:0];
      end
    end
  end

  // Counting never depends on the action field, so forced PWM levels keep the period alive.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cnt_q <= CTCP_CNT_RST;
    end else if (ce_in) begin
      if (on_rise) begin
        cnt_q <= CTCP_CNT_RST;
      end else if (run) begin
        cnt_q <= clear_now ? CTCP_CNT_RST : cnt_next;
      end
    end
  end

  // A new event wins over a software clear in the same cycle.
  for (genvar i = 0; i < CTCP_FLAG_N; i++) begin : g_flag
    always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
        flag_q[i] <= 1'b0;
      end else if (ce_in) begin
        flag_q[i] <= flag_set[i] | (flag_q[i] & ~(flag_clr_wr & pwdata_in[i]));
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pin_state_q <= 1'b0;
    end else if (ce_in) begin
      if (on_rise) begin
        pin_state_q <= init_level_q;
      end else if (run && match_a && (mode_q == CTCP_MODE_CMP)) begin
        case (action_q)
          CTCP_ACT_LOW: begin
            pin_state_q <= 1'b0;
          end
          CTCP_ACT_HIGH: begin
            pin_state_q <= 1'b1;
          end
          CTCP_ACT_TOGGLE: begin
            pin_state_q <= ~pin_state_q;
          end
          default: begin
            pin_state_q <= pin_state_q;
          end
        endcase
      end
    end
  end

  always_comb begin
    case (action_q)
      CTCP_PWM_ACT: begin
        pwm_level = 1'b1;
      end
      CTCP_PWM_RUN: begin
        pwm_level = duty_on;
      end
      default: begin
        pwm_level = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (mode_q)
      CTCP_MODE_CMP: begin
        pin_d = pin_state_q ^ invert_q;
        pin_oe_d = 1'b1;
      end
      CTCP_MODE_PWM: begin
        pin_d = (pwm_level ? init_level_q : ~init_level_q) ^ invert_q;
        pin_oe_d = 1'b1;
      end
      default: begin
        // Timer mode leaves the pin to other functions sharing it.
        pin_d = 1'b0;
        pin_oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else if (ce_in) begin
      pin_out_q <= pin_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign match_a_flag_out = flag_q[CTCP_FLAG_A];
  assign match_p_flag_out = flag_q[CTCP_FLAG_P];
  assign timer_pin_out = pin_out_q;
  assign timer_pin_oe_out = pin_oe_q;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_CNT_READ: assert property (
    (ce_in && access && !pready_q && !pwrite_in && paddr_in == CTCP_ADDR_CNT_LO)
      |=> (prdata_out[7:0] == $past(cnt_q[7:0])) && pready_out)
    else $error("counter low byte read returned wrong data");

  AST_CMPA_WRITE: assert property (
    (ce_in && wr_fire && paddr_in == CTCP_ADDR_CMP_LO)
      |=> (cmp_a_q[7:0] == $past(pwdata_in[7:0])))
    else $error("compare A low byte write not stored");

  AST_TMR_PIN_FREE: assert property (
    (ce_in && mode_q == CTCP_MODE_TMR) |=> !timer_pin_oe_out)
    else $error("pin driven in timer mode");

  AST_P_CLEAR: assert property (
    (ce_in && run && !is_pwm && !clear_sel_q && match_p)
      |=> (cnt_q == CTCP_CNT_RST) && match_p_flag_out)
    else $error("P match did not clear counter and flag");

  AST_NO_P_FLAG: assert property (
    (ce_in && !is_pwm && clear_sel_q && !match_p_flag_out) |=> !match_p_flag_out)
    else $error("P flag raised with clear-select high");

  AST_A_ZERO_WRAP: assert property (
    (ce_in && run && !is_pwm && clear_sel_q && cmp_a_q == CTCP_CNT_RST && cnt_q == CTCP_CNT_MAX
      && !match_a_flag_out && !flag_clr_wr)
      |=> (cnt_q == CTCP_CNT_RST) && !match_a_flag_out)
    else $error("zero compare A did not wrap quietly");

  AST_PIN_TOGGLE: assert property (
    (ce_in && run && match_a && mode_q == CTCP_MODE_CMP && action_q == CTCP_ACT_TOGGLE)
      |=> (pin_state_q != $past(pin_state_q)))
    else $error("toggle action did not toggle pin");

  AST_ON_RISE: assert property (
    (ce_in && on_rise) |=> (cnt_q == CTCP_CNT_RST) && (pin_state_q == $past(init_level_q)))
    else $error("timer on rise did not reset counter and pin");

  AST_PWM_FORCE: assert property (
    (ce_in && is_pwm && action_q == CTCP_PWM_ACT)
      |=> (timer_pin_out == ($past(init_level_q) ^ $past(invert_q))))
    else $error("forced active PWM level wrong");

  COV_CMP_TOGGLE: cover property (run && match_a && mode_q == CTCP_MODE_CMP && action_q == CTCP_ACT_TOGGLE);
  COV_PWM_PERIOD: cover property (run && is_pwm && clear_now);
  COV_A_CLEAR: cover property (run && !is_pwm && clear_sel_q && match_a);
  COV_FLAG_RACE: cover property (flag_clr_wr && flag_set[CTCP_FLAG_A]);
endmodule
`default_nettype wire

// ===== test/ctcp_load.sv
`default_nettype none
module ctcp_load (
  input wire logic ref_clk_in,
  input wire logic pin_in,
  input wire logic oe_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  // The line has no pull, so it wanders every cycle while nobody drives it.
  assign line_out = oe_in ? pin_in : ~last_q;
  always_ff @(posedge ref_clk_in) begin
    last_q <= line_out;
  end
endmodule
`default_nettype wire

// ===== test/test_compact_timer_compare_pwm.sv
`default_nettype none
module test_compact_timer_compare_pwm
  import ctcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, tick = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, fa, fp, pin, oe, line, rerr;
  int err_count = 0, comparisons = 0, cyc = 0;
  always #4 clk = ~clk;
  ctcp_timer DUT (.ref_clk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .count_tick_in(tick), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .match_a_flag_out(fa), .match_p_flag_out(fp),
    .timer_pin_out(pin), .timer_pin_oe_out(oe));
  ctcp_load load (.ref_clk_in(clk), .pin_in(pin), .oe_in(oe), .line_out(line));
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      end_sim;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task meas(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge clk);
      if (line === 1'b1) h++;
    end
  endtask
  function automatic logic [7:0] mk1(input logic [1:0] m, act, input logic oc, pol, swap, clr);
    return {m, act, oc, pol, swap, clr};
  endfunction
  task cfg(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] code);
    apb(1'b1, CTCP_ADDR_CTRL0, 32'h0000_0000);
    apb(1'b1, CTCP_ADDR_CTRL1, {24'h00_0000, c1});
    apb(1'b1, CTCP_ADDR_CMP_LO, {24'h00_0000, a[7:0]});
    apb(1'b1, CTCP_ADDR_CMP_HI, {30'h0000_0000, a[9:8]});
    apb(1'b1, CTCP_ADDR_STATUS, 32'h0000_0003);
    apb(1'b1, CTCP_ADDR_CTRL0, {28'h000_0000, 1'b1, code});
  endtask
  task t_regs;
    apb(1'b0, CTCP_ADDR_CNT_LO, 32'h0000_0000); chk(rdat, 32'h0000_0000);
    apb(1'b0, CTCP_ADDR_CNT_HI, 32'h0000_0000); chk(rdat, 32'h0000_0000);
    apb(1'b0, CTCP_ADDR_CMP_HI, 32'h0000_0000); chk(rdat, 32'h0000_0000);
    apb(1'b1, CTCP_ADDR_CNT_LO, 32'h0000_0055);
    apb(1'b0, CTCP_ADDR_CNT_LO, 32'h0000_0000); chk(rdat, 32'h0000_0000);
    apb(1'b1, CTCP_ADDR_CMP_LO, 32'h0000_00ff);
    apb(1'b1, CTCP_ADDR_CMP_HI, 32'h0000_0003);
    apb(1'b0, CTCP_ADDR_CMP_LO, 32'h0000_0000); chk(rdat, 32'h0000_00ff);
    apb(1'b0, CTCP_ADDR_CMP_HI, 32'h0000_0000); chk(rdat, 32'h0000_0003);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    $display("test regs done");
  endtask
  task t_cmp_clr_a;
    int h;
    cfg(mk1(CTCP_MODE_CMP, CTCP_ACT_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b1), 10'h014, 3'h3);
    repeat (100) @(posedge clk);
    meas(200, h); chk(32'(h), 32'h0000_0064);
    apb(1'b0, CTCP_ADDR_STATUS, 32'h0000_0000); chk(rdat, 32'h0000_0001);
    apb(1'b0, CTCP_ADDR_CNT_LO, 32'h0000_0000); chk(32'(rdat < 32'h0000_0014), 32'h0000_0001);
    $display("test compare clear on A done");
  endtask
  task t_cmp_clr_p;
    logic [31:0] first;
    cfg(mk1(CTCP_MODE_CMP, CTCP_ACT_LOW, 1'b1, 1'b0, 1'b0, 1'b0), 10'h032, 3'h1);
    repeat (10) @(posedge clk);
    chk({31'h0000_0000, line}, 32'h0000_0001);
    repeat (300) @(posedge clk);
    chk({31'h0000_0000, line}, 32'h0000_0000);
    apb(1'b0, CTCP_ADDR_STATUS, 32'h0000_0000); chk(rdat, 32'h0000_0003);
    apb(1'b0, CTCP_ADDR_CNT_HI, 32'h0000_0000); chk(rdat, 32'h0000_0000);
    apb(1'b1, CTCP_ADDR_CTRL0, 32'h0000_0001);
    apb(1'b0, CTCP_ADDR_CNT_LO, 32'h0000_0000);
    first = rdat;
    repeat (20) @(posedge clk);
    apb(1'b0, CTCP_ADDR_CNT_LO, 32'h0000_0000); chk(rdat, first);
    $display("test compare clear on P done");
  endtask
  task t_zero_a;
    cfg(mk1(CTCP_MODE_CMP, CTCP_ACT_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b1), 10'h000, 3'h1);
    repeat (1100) @(posedge clk);
    apb(1'b0, CTCP_ADDR_STATUS, 32'h0000_0000); chk(rdat, 32'h0000_0000);
    chk({31'h0000_0000, line}, 32'h0000_0000);
    $display("test zero compare done");
  endtask
  task t_timer;
    cfg(mk1(CTCP_MODE_TMR, CTCP_ACT_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b0), 10'h032, 3'h1);
    repeat (300) @(posedge clk);
    chk({31'h0000_0000, oe}, 32'h0000_0000);
    apb(1'b0, CTCP_ADDR_STATUS, 32'h0000_0000); chk(rdat, 32'h0000_0003);
    $display("test timer mode done");
  endtask
  task pwm_chk(input logic [7:0] c1, input logic [9:0] a, input int n, input int exp_hi, input logic [1:0] fl);
    int h;
    cfg(c1, a, 3'h1);
    repeat (300) @(posedge clk);
    meas(n, h);
    chk(32'(h), 32'(exp_hi));
    apb(1'b0, CTCP_ADDR_STATUS, 32'h0000_0000);
    chk(rdat, {30'h0000_0000, fl});
    chk({30'h0000_0000, fp, fa}, {30'h0000_0000, fl});
  endtask
  // Two counter reads 15 edges apart, with 10 of those edges frozen by ce or by the count tick.
  task t_hold;
    logic [7:0] base;
    cfg(mk1(CTCP_MODE_TMR, CTCP_ACT_NONE, 1'b0, 1'b0, 1'b0, 1'b0), 10'h000, 3'h0);
    for (int k = 0; k < 2; k++) begin
      apb(1'b0, CTCP_ADDR_CNT_LO, 32'h0000_0000);
      base = rdat[7:0];
      @(posedge clk);
      if (k == 0) begin
        ce <= 1'b0;
      end else begin
        tick <= 1'b0;
      end
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      tick <= 1'b1;
      apb(1'b0, CTCP_ADDR_CNT_LO, 32'h0000_0000);
      chk({24'h00_0000, rdat[7:0] - base}, 32'h0000_0005);
    end
    $display("test hold done");
  endtask
  task t_pwm;
    // The clear-select bit is set throughout, so any sensitivity to it in PWM shows as a wrong duty or a wrong flag.
    pwm_chk(mk1(CTCP_MODE_PWM, CTCP_PWM_RUN, 1'b1, 1'b0, 1'b0, 1'b1), 10'h020, 256, 64, 2'h3);
    pwm_chk(mk1(CTCP_MODE_PWM, CTCP_PWM_RUN, 1'b1, 1'b0, 1'b0, 1'b1), 10'h0c8, 256, 256, 2'h2);
    pwm_chk(mk1(CTCP_MODE_PWM, CTCP_PWM_RUN, 1'b1, 1'b0, 1'b1, 1'b1), 10'h0c8, 400, 256, 2'h3);
    pwm_chk(mk1(CTCP_MODE_PWM, CTCP_PWM_RUN, 1'b0, 1'b0, 1'b0, 1'b1), 10'h020, 256, 192, 2'h3);
    pwm_chk(mk1(CTCP_MODE_PWM, CTCP_PWM_RUN, 1'b1, 1'b1, 1'b0, 1'b1), 10'h020, 256, 192, 2'h3);
    pwm_chk(mk1(CTCP_MODE_PWM, CTCP_PWM_INACT, 1'b1, 1'b0, 1'b0, 1'b1), 10'h020, 256, 0, 2'h3);
    pwm_chk(mk1(CTCP_MODE_PWM, CTCP_PWM_ACT, 1'b1, 1'b0, 1'b0, 1'b1), 10'h020, 256, 256, 2'h3);
    $display("test pwm done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_cmp_clr_a;
    t_cmp_clr_p;
    t_zero_a;
    t_timer;
    t_hold;
    t_pwm;
    end_sim;
  end
endmodule
`default_nettype wire
